// ==== rtl/fault_latch_auto_retry.sv ====
/*
 * Start-up sequencing, per-output fault latching, status flags, fault pin
 * and bounded auto-retry for a dual high-side switch.
 * Assumes detector inputs asynchronous to clk_sys; registers on Wishbone.
 */
`timescale 1ns/1ps

module fault_latch_auto_retry (
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    input  wire logic                      wake_reset_pin_n,
    input  wire logic [1:0]                direct_in,
    input  wire fault_latch_pkg::detect_s  detect,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic [31:0]                    wb_dat_o,
    output logic                           wb_ack_o,
    output logic [1:0]                     out_enable,
    output logic                           fault_status_pin_n,
    output logic                           ready,
    output logic                           normal_mode,
    output fault_latch_pkg::oc_sel_s [1:0] oc_sel
);

    // -------------------------------------------------------------------
    // State record
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  wake_sync;
        logic [2:0][7:0] det_sync;
        logic [2:0][1:0] in_sync;
        logic        wake_q;
        logic        started;
        logic        watchdog_q;
        logic [11:0] ready_cnt;
        logic [31:0] ctrl;
        logic [31:0] occfg;
        logic [1:0]  ot_flag;
        logic [1:0]  oc_flag;
        logic [1:0]  sc_flag;
        logic        ov_flag;
        logic        uv_flag;
        logic [1:0]  ot_latch;
        logic [1:0]  oc_latch;
        logic [1:0]  sc_latch;
        logic [1:0]  uv_latch;
        logic [1:0]  qual_q;
        logic [1:0]  inrush;
        logic        fs_q;
        logic [1:0][1:0]  st;
        logic [1:0][4:0]  tries;
        logic [1:0][19:0] timer;
        logic [31:0] rdata;
        logic        ack;
    } state_s;

    state_s cur_ff;
    state_s nxt_ff;

    // Synchronised views, except vdd_fail_s, por_s and fs_s taken raw: stage three copies stage two every cycle, with no agreement check
    logic [7:0] det_s;
    logic [1:0] ot_s;
    logic [1:0] oc_s;
    logic [1:0] sc_s;
    logic       ov_s;
    logic       uv_s;
    logic       vdd_fail_s;
    logic       por_s;
    logic       fs_s;
    logic [1:0] in_s;
    logic       wake_s;
    logic       clear_all;
    logic       mode_chg;
    logic [1:0] qual;
    logic [1:0] qual_rise;
    logic       wb_req;
    logic       fault_rd;
    logic       pin_low;

    assign det_s  = (cur_ff.det_sync[1] == cur_ff.det_sync[2])
                  ? cur_ff.det_sync[2] : cur_ff.det_sync[2];
    assign ot_s   = {cur_ff.det_sync[2][1], cur_ff.det_sync[2][0]};
    assign in_s   = cur_ff.in_sync[2];
    assign wake_s = cur_ff.wake_sync[2];

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        logic [1:0] hit_ot;
        logic [1:0] hit_oc;
        logic [1:0] cond_gone;
        logic [1:0] retry_req;
        logic       ov_stop;
        hit_ot    = '0;
        hit_oc    = '0;
        cond_gone = '0;
        retry_req = '0;
        ov_stop   = 1'b0;
        nxt_ff = cur_ff;

        // Three-stage input synchronisers
        nxt_ff.wake_sync = {cur_ff.wake_sync[1:0], wake_reset_pin_n};
        nxt_ff.det_sync[0] = {detect.undervoltage, detect.overvoltage,
                              detect.severe_short, detect.overcurrent,
                              detect.overtemp};
        nxt_ff.det_sync[1] = cur_ff.det_sync[0];
        nxt_ff.det_sync[2] = (cur_ff.det_sync[1] == cur_ff.det_sync[2])
                           ? cur_ff.det_sync[2] : cur_ff.det_sync[1];
        nxt_ff.in_sync[0] = direct_in;
        nxt_ff.in_sync[1] = cur_ff.in_sync[0];
        nxt_ff.in_sync[2] = cur_ff.in_sync[1];
        nxt_ff.wake_q = wake_s;
        nxt_ff.fs_q   = fs_s;
        nxt_ff.qual_q = qual;
        nxt_ff.ack    = wb_req & ~cur_ff.ack;

        // Wake rising edge: registers to zero, start ready timer
        if (wake_s & ~cur_ff.wake_q) begin
            nxt_ff.ctrl      = fault_latch_pkg::RESET_WORD;
            nxt_ff.occfg     = fault_latch_pkg::RESET_WORD;
            nxt_ff.ready_cnt = 12'(fault_latch_pkg::WAKE_READY_CYC);
            nxt_ff.started   = 1'b0;
        end else if (cur_ff.ready_cnt != 12'h000) begin
            nxt_ff.ready_cnt = cur_ff.ready_cnt - 12'h001;
        end
        // Watchdog bit rising completes start-up
        if (cur_ff.ctrl[fault_latch_pkg::WDOG_POS] & ~cur_ff.watchdog_q
            & (cur_ff.ready_cnt == 12'h000))
            nxt_ff.started = 1'b1;
        nxt_ff.watchdog_q = cur_ff.ctrl[fault_latch_pkg::WDOG_POS];

        // Register writes, per byte lane
        if (wb_req & wb_we_i & ~cur_ff.ack) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    if (wb_adr_i == fault_latch_pkg::CTRL_OFS)
                        nxt_ff.ctrl[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    if (wb_adr_i == fault_latch_pkg::OCCFG_OFS)
                        nxt_ff.occfg[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
        end

        // Overvoltage: protective stop unless disabled
        ov_stop = uv_s ? 1'b0 : ov_s
                & ~cur_ff.ctrl[fault_latch_pkg::OVDIS_POS];

        for (int x = 0; x < 2; x++) begin
            // Detection while commanded on latches
            if (ot_s[x] & qual[x] & cur_ff.st[x] == 2'b00)
                hit_ot[x] = 1'b1;
            if (oc_s[x] & qual[x] & cur_ff.st[x] == 2'b00)
                hit_oc[x] = 1'b1;
            if (hit_ot[x]) nxt_ff.ot_latch[x] = 1'b1;
            if (hit_oc[x]) nxt_ff.oc_latch[x] = 1'b1;
            if (sc_s[x] & qual[x]) nxt_ff.sc_latch[x] = 1'b1;
            if (uv_s & qual[x]) nxt_ff.uv_latch[x] = 1'b1;
            cond_gone[x] = ~ot_s[x] & ~oc_s[x] & ~sc_s[x] & ~uv_s;
            retry_req[x] = cur_ff.oc_flag[x] | cur_ff.ot_flag[x]
                         | cur_ff.uv_flag;

            // Inrush profile on qualifier rise
            if (qual_rise[x]) nxt_ff.inrush[x] = 1'b1;
            else if (cur_ff.st[x] == 2'b00 & cur_ff.timer[x] == 20'h0)
                nxt_ff.inrush[x] = 1'b0;

            unique case (fault_latch_pkg::out_state_e'(cur_ff.st[x]))
                fault_latch_pkg::OUT_RUN: begin
                    if (nxt_ff.ot_latch[x] | nxt_ff.oc_latch[x]
                        | nxt_ff.sc_latch[x] | nxt_ff.uv_latch[x])
                        nxt_ff.st[x] = fault_latch_pkg::OUT_LATCH;
                    if (cur_ff.timer[x] != 20'h0)
                        nxt_ff.timer[x] = cur_ff.timer[x] - 20'h1;
                end
                fault_latch_pkg::OUT_LATCH: begin
                    nxt_ff.timer[x] =
                        20'(fault_latch_pkg::RETRY_PERIOD_CYC);
                    if (cond_gone[x] & qual_rise[x])
                        nxt_ff.st[x] = fault_latch_pkg::OUT_RUN;
                    else if (cur_ff.sc_latch[x])
                        nxt_ff.st[x] = fault_latch_pkg::OUT_LATCH;
                    else if (retry_req[x]
                             & cur_ff.tries[x] < fault_latch_pkg::RETRY_LIMIT)
                        nxt_ff.st[x] = fault_latch_pkg::OUT_WAIT;
                    else if (retry_req[x])
                        nxt_ff.st[x] = fault_latch_pkg::OUT_DEAD;
                end
                fault_latch_pkg::OUT_WAIT: begin
                    if (cond_gone[x] & qual_rise[x])
                        nxt_ff.st[x] = fault_latch_pkg::OUT_RUN;
                    else if (cur_ff.timer[x] != 20'h0)
                        nxt_ff.timer[x] = cur_ff.timer[x] - 20'h1;
                    else if (cond_gone[x]) begin
                        nxt_ff.tries[x] = cur_ff.tries[x] + 5'h01;
                        nxt_ff.inrush[x] = 1'b1;
                        nxt_ff.timer[x] =
                            20'(fault_latch_pkg::RETRY_PERIOD_CYC);
                        nxt_ff.st[x] = fault_latch_pkg::OUT_RUN;
                    end
                    if (nxt_ff.st[x] == 2'b00 | cur_ff.timer[x] == 20'h0)
                        {nxt_ff.ot_latch[x], nxt_ff.oc_latch[x],
                         nxt_ff.uv_latch[x]} = 3'b000;
                end
                fault_latch_pkg::OUT_DEAD: begin
                    if (cond_gone[x] & qual_rise[x]) begin
                        nxt_ff.st[x] = fault_latch_pkg::OUT_RUN;
                        nxt_ff.tries[x] = 5'h00;
                    end
                end
            endcase
            if (nxt_ff.st[x] == 2'b00 & cur_ff.st[x] != 2'b00 &
                cur_ff.st[x] != 2'b11) begin
                nxt_ff.ot_latch[x] = 1'b0;
                nxt_ff.oc_latch[x] = 1'b0;
                nxt_ff.sc_latch[x] = 1'b0;
                nxt_ff.uv_latch[x] = 1'b0;
            end
        end

        // Flags: read clears, a new event wins over the clear
        if (fault_rd) begin
            nxt_ff.ot_flag = '0;
            nxt_ff.oc_flag = '0;
            nxt_ff.sc_flag = '0;
            nxt_ff.ov_flag = ov_s & cur_ff.ctrl[fault_latch_pkg::OVDIS_POS];
            nxt_ff.uv_flag = 1'b0;
        end
        nxt_ff.ot_flag = nxt_ff.ot_flag | ot_s;
        nxt_ff.oc_flag = nxt_ff.oc_flag | hit_oc;
        nxt_ff.sc_flag = nxt_ff.sc_flag | sc_s;
        nxt_ff.ov_flag = nxt_ff.ov_flag | ov_s;
        nxt_ff.uv_flag = nxt_ff.uv_flag | uv_s;
        if (ov_stop) nxt_ff.ov_flag = 1'b1;

        // Mode changes and supply failures clear latches and retries
        if (clear_all | mode_chg) begin
            nxt_ff.ot_latch = '0;
            nxt_ff.oc_latch = '0;
            nxt_ff.sc_latch = '0;
            nxt_ff.uv_latch = '0;
            nxt_ff.tries    = '0;
            nxt_ff.st       = '0;
        end
        if (clear_all) begin
            nxt_ff.ctrl  = fault_latch_pkg::RESET_WORD;
            nxt_ff.occfg = fault_latch_pkg::RESET_WORD;
        end

        // Read data mux, unmapped reads zero
        unique case (wb_adr_i)
            fault_latch_pkg::CTRL_OFS:  nxt_ff.rdata = cur_ff.ctrl;
            fault_latch_pkg::OCCFG_OFS: nxt_ff.rdata = cur_ff.occfg;
            fault_latch_pkg::FAULT_OFS:
                nxt_ff.rdata = {24'h00_0000, cur_ff.uv_flag, cur_ff.ov_flag,
                                cur_ff.sc_flag, cur_ff.oc_flag,
                                cur_ff.ot_flag};
            fault_latch_pkg::STATE_OFS:
                nxt_ff.rdata = {16'h0000, cur_ff.tries[1][3:0],
                                cur_ff.tries[0][3:0], cur_ff.st[1],
                                cur_ff.st[0], 2'b00, cur_ff.started,
                                ~fs_s};
            default:                    nxt_ff.rdata = 32'h0000_0000;
        endcase
    end

    // -------------------------------------------------------------------
    // Decoded views
    // -------------------------------------------------------------------
    assign oc_s       = {cur_ff.det_sync[2][3], cur_ff.det_sync[2][2]};
    assign sc_s       = {cur_ff.det_sync[2][5], cur_ff.det_sync[2][4]};
    assign ov_s       = cur_ff.det_sync[2][6];
    assign uv_s       = cur_ff.det_sync[2][7];
    assign vdd_fail_s = detect.logic_supply_fail;
    assign por_s      = detect.supply_por;
    assign fs_s       = detect.fail_safe;
    assign clear_all  = vdd_fail_s | por_s | ~wake_s;
    assign mode_chg   = fs_s ^ cur_ff.fs_q;
    assign wb_req     = wb_cyc_i & wb_stb_i;
    assign fault_rd   = wb_req & ~wb_we_i & ~cur_ff.ack
                      & (wb_adr_i == fault_latch_pkg::FAULT_OFS);
    assign qual_rise  = qual & ~cur_ff.qual_q;

    // Qualifier: direct input when not disabled and PWM off, or on bit
    always_comb begin
        for (int x = 0; x < 2; x++) begin
            qual[x] = (in_s[x] & ~cur_ff.ctrl[fault_latch_pkg::DIRDIS_POS+x]
                       & ~cur_ff.ctrl[fault_latch_pkg::PWMEN_POS])
                    | cur_ff.ctrl[fault_latch_pkg::ON_POS+x];
        end
    end

    // Output and pin drive
    always_comb begin
        pin_low = ov_s | uv_s;
        for (int x = 0; x < 2; x++) begin
            out_enable[x] = qual[x] & cur_ff.st[x] == 2'b00
                          & ~(ov_s & ~cur_ff.ctrl[fault_latch_pkg::OVDIS_POS])
                          & ~uv_s & wake_s;
            // Latched fault holds pin; off-state overtemp is live
            pin_low = pin_low | cur_ff.st[x] != 2'b00
                    | ot_s[x] | sc_s[x];
            oc_sel[x].profile = cur_ff.occfg[8*x + fault_latch_pkg::PROF_POS
                                             +: 2];
            oc_sel[x].inrush = cur_ff.inrush[x];
            oc_sel[x].inrush_slope_sel =
                cur_ff.inrush[x] & cur_ff.tries[x] != 5'h00 ? 2'b00 :
                cur_ff.occfg[8*x + fault_latch_pkg::SLOPE_POS +: 2];
            oc_sel[x].skip_first_step_bit =
                cur_ff.occfg[8*x + fault_latch_pkg::SKIP_POS];
            oc_sel[x].steady_level_sel =
                cur_ff.occfg[8*x + fault_latch_pkg::STEADY_POS +: 2];
            oc_sel[x].cooling_emulation =
                cur_ff.occfg[8*x + fault_latch_pkg::COOLEN_POS]
                & cur_ff.occfg[8*x + fault_latch_pkg::PROF_POS]
                & cur_ff.ctrl[fault_latch_pkg::PWMEN_POS] & ~fs_s;
            oc_sel[x].cooling_slope_sel =
                cur_ff.occfg[fault_latch_pkg::COOLSL_POS + 2*x +: 2];
        end
    end

    assign fault_status_pin_n = ~pin_low;
    assign ready       = wake_s & (cur_ff.ready_cnt == 12'h000);
    assign normal_mode = cur_ff.started & ~fs_s;
    assign wb_ack_o    = cur_ff.ack;
    assign wb_dat_o    = cur_ff.rdata;

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence latch_seq(int x);
        cur_ff.st[x] == 2'b01;
    endsequence

    latch_pin_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cur_ff.st[0] != 2'b00 |-> !fault_status_pin_n)
        else $error("latched output without fault pin");
    latch_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        latch_seq(1) |-> !out_enable[1])
        else $error("latched output still enabled");
    sc_noretry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cur_ff.sc_latch[0] && cur_ff.st[0] == 2'b01 && !qual_rise[0]
        |=> cur_ff.st[0] != 2'b11)
        else $error("severe short entered retry");
    retry_cap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cur_ff.tries[0] <= 5'h10)
        else $error("retry count above limit");
    ov_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ov_s && !cur_ff.ctrl[5] |-> out_enable == 2'b00)
        else $error("output on during overvoltage");
    uv_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        uv_s |=> cur_ff.uv_flag)
        else $error("undervoltage flag not set");
    mode_clr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        mode_chg |=> cur_ff.tries == '0)
        else $error("retry count kept over mode change");
    ready_time_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(wake_s) |=> !ready [*8])
        else $error("ready too early after wake");

endmodule // fault_latch_auto_retry

// ==== rtl/fault_latch_pkg.sv ====
/*
 * Shared constants and carrier types for the fault latch and auto-retry
 * block of a dual high-side switch.
 * Assumes a 50 MHz system clock and a classic Wishbone register bus.
 */
package fault_latch_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned WAKE_READY_US   = 50;
    localparam int unsigned WAKE_READY_CYC  =
        (WAKE_READY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RETRY_PERIOD_US = 10_000;
    localparam int unsigned RETRY_PERIOD_CYC =
        (RETRY_PERIOD_US * (CLK_HZ / 1_000_000));
    localparam logic [4:0]  RETRY_LIMIT     = 5'h10;
    localparam int unsigned NUM_OUT         = 2;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] OCCFG_OFS  = 8'h04;
    localparam logic [7:0] FAULT_OFS  = 8'h08;
    localparam logic [7:0] STATE_OFS  = 8'h0C;

    // CTRL fields
    localparam int unsigned ON_POS      = 0;  // two bits
    localparam int unsigned DIRDIS_POS  = 2;  // two bits
    localparam int unsigned PWMEN_POS   = 4;
    localparam int unsigned OVDIS_POS   = 5;
    localparam int unsigned WDOG_POS    = 6;
    // OCCFG fields, per output byte at 8*x; cooling slope pairs at 16+2*x
    localparam int unsigned PROF_POS    = 0;  // two bits
    localparam int unsigned SLOPE_POS   = 2;  // two bits
    localparam int unsigned SKIP_POS    = 4;
    localparam int unsigned STEADY_POS  = 5;  // two bits
    localparam int unsigned COOLEN_POS  = 7;
    localparam int unsigned COOLSL_POS  = 16; // two bits per output
    // FAULT fields
    localparam int unsigned OT_POS      = 0;
    localparam int unsigned OC_POS      = 2;
    localparam int unsigned SC_POS      = 4;
    localparam int unsigned OV_POS      = 6;
    localparam int unsigned UV_POS      = 7;

    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

    // Profiles: 0 discharge lamp (default), 1 large bulb, 2 small bulb
    typedef enum logic [1:0] {
        PROF_LAMP  = 2'b00,
        PROF_LARGE = 2'b01,
        PROF_SMALL = 2'b10
    } oc_profile_e;

    typedef enum logic [1:0] {
        OUT_RUN   = 2'b00,
        OUT_LATCH = 2'b01,
        OUT_WAIT  = 2'b11,
        OUT_DEAD  = 2'b10
    } out_state_e;

    // Analog detector inputs
    typedef struct packed {
        logic [1:0] overtemp;
        logic [1:0] overcurrent;
        logic [1:0] severe_short;
        logic       overvoltage;
        logic       undervoltage;
        logic       logic_supply_fail;
        logic       supply_por;
        logic       fail_safe;
    } detect_s;

    // Per-output overcurrent selection
    typedef struct packed {
        logic [1:0] profile;
        logic       inrush;
        logic [1:0] inrush_slope_sel;
        logic       skip_first_step_bit;
        logic [1:0] steady_level_sel;
        logic       cooling_emulation;
        logic [1:0] cooling_slope_sel;
    } oc_sel_s;

endpackage

// ==== test/host_model.sv ====
/*
 * Host side model: classic Wishbone master tasks for register access.
 * Assumes a slave that acks every request exactly once.
 */
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_sys,
    input  wire logic        wb_ack_o,
    input  wire logic [31:0] wb_dat_o,
    output logic             wb_cyc_i,
    output logic             wb_stb_i,
    output logic             wb_we_i,
    output logic [7:0]       wb_adr_i,
    output logic [3:0]       wb_sel_i,
    output logic [31:0]      wb_dat_i
);
    // Idle bus at time zero
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    end

    // One classic cycle; address and data scrambled once released
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hf, d};
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        {wb_adr_i, wb_dat_i} <= {~a, ~d};
        @(posedge clk_sys);
    endtask
endmodule // host_model

// ==== test/testbench.sv ====
/*
 * Bench: drives wake, detectors and host traffic; checks pin and outputs.
 * Assumes package constants and a 3-flop detector synchroniser.
 */
`timescale 1ns/1ps
module testbench;
    logic                           clk_sys = 1'b0;
    logic                           sys_rst = 1'b1;
    logic                           wake_reset_pin_n = 1'b0;
    fault_latch_pkg::detect_s       det = '0;
    fault_latch_pkg::oc_sel_s [1:0] ocs;
    logic                           cyc, stb, we, ack, pin_n, rdy, nm;
    logic [7:0]                     adr;
    logic [3:0]                     sel;
    logic [31:0]                    dw, dr, q, rnd;
    logic [1:0]                     oen;
    int                             bad_count = 0;
    int                             n_compared = 0;

    always #10 clk_sys = ~clk_sys;

    fault_latch_auto_retry u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .wake_reset_pin_n(wake_reset_pin_n), .direct_in(2'b00),
        .detect(det), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .out_enable(oen), .fault_status_pin_n(pin_n),
        .ready(rdy), .normal_mode(nm), .oc_sel(ocs));
    host_model u_host (
        .clk_sys(clk_sys), .wb_ack_o(ack), .wb_dat_o(dr), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dw));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, s);
        n_compared++;
        if (e !== s) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0000_0000, q);
        chk("read", e, q);
    endtask
    // Set one detector bit, then let the synchroniser catch up
    task automatic drv(input int k, input logic v);
        @(posedge clk_sys) det[k] <= v;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    task automatic pins(input logic [1:0] e_oen, input logic e_pin);
        chk("out_enable", {30'h0, e_oen}, {30'h0, oen});
        chk("fault_pin", {31'h0, e_pin}, {31'h0, pin_n});
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (12000) @(posedge clk_sys);
        bad_count++;
        final_report();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        rnd = 32'h0000_2dab;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        drv(0, 1'b0);
        @(posedge clk_sys) wake_reset_pin_n <= 1'b1;
        drv(0, 1'b0);
        chk("ready_early", 32'h0, {31'h0, rdy});
        repeat (fault_latch_pkg::WAKE_READY_CYC + 10) @(posedge clk_sys);
        #1 chk("ready", 32'h1, {31'h0, rdy});
        rd(fault_latch_pkg::CTRL_OFS, 32'h0);
        rd(8'h3c, 32'h0);
        wr(fault_latch_pkg::CTRL_OFS, 32'h03);
        wr(fault_latch_pkg::CTRL_OFS, 32'h43);
        drv(0, 1'b0);
        chk("normal", 32'h1, {31'h0, nm});
        pins(2'b11, 1'b1);
        // Random overcurrent selection reaches the detector controls
        repeat (4) begin
            rnd = lfsr(rnd);
            wr(fault_latch_pkg::OCCFG_OFS, rnd & 32'h000f_fdfd);
            #1 chk("oc_sel", {21'h0, rnd[9:8] & 2'b01, rnd[3:2], rnd[4],
                rnd[6:5], rnd[17:16]}, {21'h0, ocs[1].profile,
                ocs[0].inrush_slope_sel, ocs[0].skip_first_step_bit,
                ocs[0].steady_level_sel, ocs[0].cooling_slope_sel});
        end
        // Latching faults: overtemp, overcurrent, severe short per output
        for (int b = 0; b < 6; b++) begin
            drv(9 - 2 * (b / 2) + b % 2, 1'b1);
            pins(2'b11 & ~(2'b01 << b % 2), 1'b0);
            drv(9 - 2 * (b / 2) + b % 2, 1'b0);
            pins(2'b11 & ~(2'b01 << b % 2), 1'b0);
            rd(fault_latch_pkg::FAULT_OFS, 32'h1 << b);
            rd(fault_latch_pkg::FAULT_OFS, 32'h0);
            wr(fault_latch_pkg::CTRL_OFS, 32'h40);
            wr(fault_latch_pkg::CTRL_OFS, 32'h43);
            drv(0, 1'b0);
            pins(2'b11, 1'b1);
        end
        // Overtemperature while commanded off
        wr(fault_latch_pkg::CTRL_OFS, 32'h40);
        drv(9, 1'b1);
        pins(2'b00, 1'b0);
        drv(9, 1'b0);
        pins(2'b00, 1'b1);
        rd(fault_latch_pkg::FAULT_OFS, 32'h1);
        // Overvoltage with protection on, then as a warning only
        wr(fault_latch_pkg::CTRL_OFS, 32'h43);
        drv(4, 1'b1);
        pins(2'b00, 1'b0);
        drv(4, 1'b0);
        pins(2'b11, 1'b1);
        rd(fault_latch_pkg::FAULT_OFS, 32'h40);
        wr(fault_latch_pkg::CTRL_OFS, 32'h63);
        drv(4, 1'b1);
        rd(fault_latch_pkg::FAULT_OFS, 32'h40);
        rd(fault_latch_pkg::FAULT_OFS, 32'h40);
        drv(4, 1'b0);
        rd(fault_latch_pkg::FAULT_OFS, 32'h40);
        rd(fault_latch_pkg::FAULT_OFS, 32'h0);
        // Undervoltage recovery with outputs off
        wr(fault_latch_pkg::CTRL_OFS, 32'h40);
        drv(3, 1'b1);
        pins(2'b00, 1'b0);
        drv(3, 1'b0);
        pins(2'b00, 1'b1);
        rd(fault_latch_pkg::FAULT_OFS, 32'h80);
        rd(fault_latch_pkg::FAULT_OFS, 32'h0);
        final_report();
    end
endmodule // testbench
